// File: verilog/pwr_pkg.sv
// Constants for the power-mode and wake-up control block.
// Assumes an 8-bit special function register port on the system clock.
package pwr_pkg;
    localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_WAKE_CONFIG_FLAGS = 8'hb5;
    localparam logic [3:0] PAGE_WAKE_CONFIG_FLAGS = 4'h0;
    localparam int BIT_SLEEP = 7;
    localparam int BIT_SUSPEND = 6;
    localparam int BIT_CLEAR = 5;
    localparam int BIT_RESET_PIN_WAKE = 4;
    localparam int BIT_RTC_OSC_FAIL = 3;
    localparam int BIT_RTC_ALARM = 2;
    localparam int BIT_PORT_MATCH = 1;
    localparam int BIT_COMPARATOR = 0;
    localparam int BIT_STOP = 1;
    localparam int BIT_IDLE = 0;
    localparam int GP_FLAGS_LSB = 2;
    localparam int GP_FLAGS_W = 6;
    localparam int SRC_W = 4;
    localparam logic [7:0] POWER_MODE_CONTROL_RESET = 8'h00;
    localparam logic [3:0] WAKE_ENABLE_RESET = 4'h0;
    localparam logic [1:0] SUSPEND_HIDE_CYCLES = 2'h2;
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SUSPEND = 2'b01,
        MODE_SLEEP = 2'b10,
        MODE_WAKE_HIDE = 2'b11
    } mode_e;
endpackage

// File: verilog/pwr_if.sv
// Bundle between the register front end and the wake flag store.
// Both ends run on the same system clock.
`timescale 1ns/100ps
interface pwr_if;
    logic clear;
    logic [pwr_pkg::SRC_W-1:0] src_event;
    logic reset_pin_fall;
    logic [pwr_pkg::SRC_W-1:0] src_flags;
    logic reset_pin_flag;
    modport ctrl (output clear, output src_event, output reset_pin_fall,
        input src_flags, input reset_pin_flag);
    modport store (input clear, input src_event, input reset_pin_fall,
        output src_flags, output reset_pin_flag);
endinterface

// File: verilog/wake_flag_store.sv
// Sticky wake-up flags, set by events and cleared all at once.
// Event inputs are already synchronous single-cycle pulses.
`timescale 1ns/100ps
module wake_flag_store (
    input wire logic ref_clk,
    input wire logic rstn,
    pwr_if.store bus
);
    logic [pwr_pkg::SRC_W-1:0] flags_q, flags_d;
    logic rst_flag_q, rst_flag_d;

    // Set wins over a clear landing in the same cycle
    always_comb begin
        flags_d = bus.clear ? '0 : flags_q;
        flags_d = flags_d | bus.src_event;
        rst_flag_d = (bus.clear ? 1'b0 : rst_flag_q) | bus.reset_pin_fall;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            flags_q <= '0;
            rst_flag_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            rst_flag_q <= rst_flag_d;
        end
    end

    assign bus.src_flags = flags_q;
    assign bus.reset_pin_flag = rst_flag_q;
endmodule

// File: verilog/power_mode_wake_control.sv
// Power-mode control and wake-up source logic with its two registers.
// Assumes a synchronous SFR port; wake events arrive as pins from other
// peripherals and are synchronised here.
// Operation
// - Writing one to wake config bit 7 enters sleep; write-only, reads zero.
// - Writing one to wake config bit 6 enters suspend; write-only, reads zero.
// - Writing one to wake config bit 5 clears all wake flags.
// - Bit 4 reads one after a reset pin falling edge; writes ignored.
// - Bit 3 enables oscillator-fail wake; reads oscillator failed flag.
// - Bit 2 enables alarm wake; reads alarm occurred flag.
// - Bit 1 enables port match wake; reads port match flag.
// - Bit 0 enables comparator rising wake; reads comparator wake flag.
// - Any set flag blocks sleep/suspend entry and keeps low-power oscillator on.
// - Power control bits 7:2 are six read/write general-purpose flags.
// - Writing one to power control bit 1 enters stop mode.
// - Writing one to power control bit 0 enters idle mode.
// - Power control answers at 0x87 in every page.
// - Flags update on every event, enabled or not, always.
// - Reset pin falling edge always wakes from sleep.
// - Flags read zero for two clocks after leaving suspend.
`timescale 1ns/100ps
module power_mode_wake_control (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic rst_pin_n,
    input wire logic rtc_osc_fail_evt,
    input wire logic rtc_alarm_evt,
    input wire logic port_match_evt,
    input wire logic comparator_rise_evt,
    output logic sleep_mode,
    output logic suspend_mode,
    output logic stop_req,
    output logic idle_req,
    output logic lp_osc_keep_on
);
    pwr_if wb ();

    wake_flag_store u_store (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .bus(wb.store)
    );

    // Two-stage synchronisers; stage one feeds only stage two
    logic [4:0] sync1_q;
    logic [4:0] sync1_d;
    logic [4:0] sync2_q;
    logic [4:0] sync2_d;
    logic [4:0] prev_q;
    logic [4:0] prev_d;
    logic [4:0] raw;
    assign raw = {rst_pin_n, rtc_osc_fail_evt, rtc_alarm_evt, port_match_evt,
        comparator_rise_evt};

    always_comb begin
        sync1_d = raw;
        sync2_d = sync1_q;
        prev_d = sync2_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            // All ones: an idle reset pin and a source already high give no edge
            sync1_q <= 5'h1f;
            sync2_q <= 5'h1f;
            prev_q <= 5'h1f;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
        end
    end

    logic [pwr_pkg::SRC_W-1:0] src_rise;
    logic rst_fall;
    assign src_rise = sync2_q[3:0] & ~prev_q[3:0];
    // The reset pin is active low, so its event is a fall, the sources' a rise
    assign rst_fall = prev_q[4] & ~sync2_q[4];

    logic wr_wake;
    logic wr_power_mode_control;
    logic rd_wake;
    logic rd_power_mode_control;
    assign wr_wake = sfr_wr && sfr_addr == pwr_pkg::ADDR_WAKE_CONFIG_FLAGS
        && sfr_page == pwr_pkg::PAGE_WAKE_CONFIG_FLAGS;
    assign rd_wake = sfr_rd && sfr_addr == pwr_pkg::ADDR_WAKE_CONFIG_FLAGS
        && sfr_page == pwr_pkg::PAGE_WAKE_CONFIG_FLAGS;
    assign wr_power_mode_control = sfr_wr && sfr_addr == pwr_pkg::ADDR_POWER_MODE_CONTROL;
    assign rd_power_mode_control = sfr_rd && sfr_addr == pwr_pkg::ADDR_POWER_MODE_CONTROL;
    // Only reads are answered; writes need no hit
    assign sfr_hit = rd_wake | rd_power_mode_control;

    logic clear_wr;
    assign clear_wr = wr_wake && sfr_wdata[pwr_pkg::BIT_CLEAR];
    assign wb.clear = clear_wr;
    assign wb.src_event = src_rise;
    assign wb.reset_pin_fall = rst_fall;

    // The reset-pin flag counts too, so a pin glitch also blocks entry
    logic any_flag;
    assign any_flag = |wb.src_flags | wb.reset_pin_flag;

    // Register state and mode sequencer
    pwr_pkg::mode_e mode_q;
    pwr_pkg::mode_e mode_d;
    logic [pwr_pkg::SRC_W-1:0] en_q;
    logic [pwr_pkg::SRC_W-1:0] en_d;
    logic [pwr_pkg::GP_FLAGS_W-1:0] gpf_q;
    logic [pwr_pkg::GP_FLAGS_W-1:0] gpf_d;
    logic [1:0] hide_q;
    logic [1:0] hide_d;
    logic stop_q;
    logic stop_d;
    logic idle_q;
    logic idle_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wake_hit;

    // Source rise events are counted only if enabled, not the stored flags; the reset pin always wakes
    assign wake_hit = |(src_rise & en_q) || rst_fall;

    always_comb begin
        mode_d = mode_q;
        en_d = en_q;
        gpf_d = gpf_q;
        hide_d = hide_q;
        // Stop and idle are one-cycle requests to the core and never stay set
        stop_d = 1'b0;
        idle_d = 1'b0;
        if (wr_wake) begin
            en_d = sfr_wdata[pwr_pkg::SRC_W-1:0];
        end
        if (wr_power_mode_control) begin
            gpf_d = sfr_wdata[7:pwr_pkg::GP_FLAGS_LSB];
            stop_d = sfr_wdata[pwr_pkg::BIT_STOP];
            idle_d = sfr_wdata[pwr_pkg::BIT_IDLE];
        end
        case (mode_q)
            pwr_pkg::MODE_RUN: begin
                // Flags already set, or cleared by this same write, still block
                if (wr_wake && !any_flag) begin
                    if (sfr_wdata[pwr_pkg::BIT_SLEEP]) begin
                        mode_d = pwr_pkg::MODE_SLEEP;
                    end else if (sfr_wdata[pwr_pkg::BIT_SUSPEND]) begin
                        mode_d = pwr_pkg::MODE_SUSPEND;
                    end
                end
            end
            pwr_pkg::MODE_SLEEP: begin
                if (wake_hit) begin
                    mode_d = pwr_pkg::MODE_RUN;
                end
            end
            pwr_pkg::MODE_SUSPEND: begin
                if (wake_hit) begin
                    mode_d = pwr_pkg::MODE_WAKE_HIDE;
                    hide_d = pwr_pkg::SUSPEND_HIDE_CYCLES;
                end
            end
            pwr_pkg::MODE_WAKE_HIDE: begin
                // Counts down the cycles in which wake flag reads stay hidden
                hide_d = hide_q - 2'h1;
                if (hide_q == 2'h1) begin
                    mode_d = pwr_pkg::MODE_RUN;
                end
            end
            default: mode_d = pwr_pkg::MODE_RUN;
        endcase
    end

    // Write-only bits read as zero; flags hidden right after suspend
    always_comb begin
        rdata_d = 8'h00;
        if (rd_wake && mode_q != pwr_pkg::MODE_WAKE_HIDE) begin
            rdata_d[pwr_pkg::BIT_RESET_PIN_WAKE] = wb.reset_pin_flag;
            rdata_d[pwr_pkg::SRC_W-1:0] = wb.src_flags;
        end else if (rd_power_mode_control) begin
            rdata_d = {gpf_q, 2'b00};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mode_q <= pwr_pkg::MODE_RUN;
            en_q <= pwr_pkg::WAKE_ENABLE_RESET;
            gpf_q <= pwr_pkg::POWER_MODE_CONTROL_RESET[7:2];
            hide_q <= 2'h0;
            stop_q <= 1'b0;
            idle_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            mode_q <= mode_d;
            en_q <= en_d;
            gpf_q <= gpf_d;
            hide_q <= hide_d;
            stop_q <= stop_d;
            idle_q <= idle_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign sleep_mode = mode_q == pwr_pkg::MODE_SLEEP;
    assign suspend_mode = mode_q == pwr_pkg::MODE_SUSPEND;
    assign stop_req = stop_q;
    assign idle_req = idle_q;
    assign lp_osc_keep_on = any_flag;
endmodule

// File: bench/power_mode_wake_control_props.sv
// Port checker for the power-mode and wake-up control block.
// Bound onto the top module from the bench; single clock domain.
`timescale 1ns/100ps
module power_mode_wake_props (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [3:0] sfr_page,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic rst_pin_n,
    input wire logic sleep_mode,
    input wire logic suspend_mode,
    input wire logic stop_req,
    input wire logic idle_req,
    input wire logic lp_osc_keep_on
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic wk, pc, run;
    assign wk = sfr_addr == 8'hb5 && sfr_page == 4'h0;
    assign pc = sfr_addr == 8'h87;
    assign run = !sleep_mode && !suspend_mode;
    a_hit_map: assert property (sfr_hit == (sfr_rd && (pc || wk)))
        else $error("hit flag does not match the address map");
    a_rdata_quiet: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not zero without a read");
    a_power_mode_control_wo: assert property (sfr_rd && pc |=> sfr_rdata[1:0] == 2'b00)
        else $error("mode select bits readable");
    a_wake_wo: assert property (sfr_rd && wk |=> sfr_rdata[7:5] == 3'b000)
        else $error("write-only wake bits readable");
    a_stop_pulse: assert property (sfr_wr && pc && sfr_wdata[1] |=> stop_req)
        else $error("stop request missing");
    a_idle_cause: assert property (!(sfr_wr && pc && sfr_wdata[0]) |=> !idle_req)
        else $error("idle request without write");
    a_sleep_enter: assert property (sfr_wr && wk && sfr_wdata[7] && run
        && !lp_osc_keep_on |=> sleep_mode && !suspend_mode)
        else $error("sleep not entered");
    a_susp_enter: assert property (sfr_wr && wk && sfr_wdata[7:6] == 2'b01 && run
        && !lp_osc_keep_on |=> suspend_mode)
        else $error("suspend not entered");
    a_flag_block: assert property (run && lp_osc_keep_on |=> run)
        else $error("low-power mode entered with a flag set");
    a_mode_excl: assert property (!(sleep_mode && suspend_mode))
        else $error("sleep and suspend both active");
    a_pin_wake: assert property (sleep_mode && $fell(rst_pin_n) |-> ##[1:4] !sleep_mode)
        else $error("reset pin fall did not end sleep");
    a_hide_read: assert property ($fell(suspend_mode) && sfr_rd && wk
        |=> sfr_rdata[4:0] == 5'h00)
        else $error("wake flags readable right after suspend");
endmodule

// File: bench/test_power_mode_wake_control.sv
// Self-checking bench for the power-mode and wake-up control block.
// Drives the register port and event pins itself; one 100 MHz clock.
`timescale 1ns/100ps
module test_power_mode_wake_control;
    logic ref_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, fl = 8'h00, d;
    logic [3:0] sfr_page = 4'h0;
    logic [4:0] ev = 5'h00;
    logic sfr_hit, sleep_mode, suspend_mode, stop_req, idle_req, lp_osc_keep_on;
    logic [31:0] s = 32'he449e65d;
    logic hit_seen = 1'b0;
    int err_total = 0, comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    // Bit 4 of the event vector drives the reset pin, so a rise there is its falling edge
    power_mode_wake_control power_mode_wake_control_i (.ref_clk, .rstn, .sfr_wr, .sfr_rd,
        .sfr_addr, .sfr_page, .sfr_wdata, .sfr_rdata, .sfr_hit, .rst_pin_n(!ev[4]),
        .rtc_osc_fail_evt(ev[3]), .rtc_alarm_evt(ev[2]), .port_match_evt(ev[1]),
        .comparator_rise_evt(ev[0]), .sleep_mode, .suspend_mode, .stop_req, .idle_req,
        .lp_osc_keep_on);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, v, input logic [3:0] p);
        @(posedge ref_clk);
        sfr_wr <= w;
        sfr_rd <= !w;
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_page <= p;
        @(negedge ref_clk);
        hit_seen = sfr_hit;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk);
        ev[i] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ev[i] <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        fl[i] = 1'b1;
    endtask
    task automatic wake;
        int k;
        k = 0;
        while ((sleep_mode || suspend_mode) && k < 20) begin
            @(negedge ref_clk);
            k++;
        end
        chk("awake", 8'h00, {6'h0, sleep_mode, suspend_mode});
        if (sleep_mode || suspend_mode) summarize();
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        acc(0, 8'h87, 8'h00, 4'h5);
        chk("gp reset", 8'h00, sfr_rdata);
        chk("gp hit", 8'h01, {7'h0, hit_seen});
        acc(0, 8'hb5, 8'h00, 4'h0);
        chk("flags reset", 8'h00, sfr_rdata);
        chk("wake hit", 8'h01, {7'h0, hit_seen});
        acc(0, 8'h55, 8'h00, 4'h0);
        chk("unmapped", 8'h00, sfr_rdata);
        chk("unmapped hit", 8'h00, {7'h0, hit_seen});
        acc(0, 8'hb5, 8'h00, 4'h3);
        chk("wrong page", 8'h00, sfr_rdata);
        chk("wrong page hit", 8'h00, {7'h0, hit_seen});
        for (int k = 0; k < 4; k++) begin
            s = lfsr(s);
            d = {s[7:2], k[1:0]};
            acc(1, 8'h87, d, s[11:8]);
            chk("stop idle", {6'h0, d[1:0]}, {6'h0, stop_req, idle_req});
            acc(0, 8'h87, 8'h00, s[15:12]);
            chk("gp flags", {d[7:2], 2'b00}, sfr_rdata);
            chk("gp page hit", 8'h01, {7'h0, hit_seen});
        end
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            acc(0, 8'hb5, 8'h00, 4'h0);
            chk("flag set", fl, sfr_rdata);
        end
        acc(1, 8'hb5, 8'h80, 4'h0);
        chk("refused", 8'h00, {6'h0, sleep_mode, suspend_mode});
        chk("osc kept", 8'h01, {7'h0, lp_osc_keep_on});
        acc(1, 8'hb5, 8'h30, 4'h0);
        fl = 8'h00;
        acc(0, 8'hb5, 8'h00, 4'h0);
        chk("cleared", fl, sfr_rdata);
        $display("test flags done");
        acc(1, 8'hb5, 8'h82, 4'h0);
        chk("sleep", 8'h02, {6'h0, sleep_mode, suspend_mode});
        pulse(2);
        chk("no wake", 8'h02, {6'h0, sleep_mode, suspend_mode});
        pulse(1);
        wake();
        acc(0, 8'hb5, 8'h00, 4'h0);
        chk("wake cause", fl, sfr_rdata);
        acc(1, 8'hb5, 8'h20, 4'h0);
        fl = 8'h00;
        acc(1, 8'hb5, 8'h80, 4'h0);
        chk("pin sleep", 8'h02, {6'h0, sleep_mode, suspend_mode});
        pulse(4);
        wake();
        acc(0, 8'hb5, 8'h00, 4'h0);
        chk("pin cause", fl, sfr_rdata);
        acc(1, 8'hb5, 8'h20, 4'h0);
        fl = 8'h00;
        acc(1, 8'hb5, 8'hc8, 4'h0);
        chk("sleep wins", 8'h02, {6'h0, sleep_mode, suspend_mode});
        pulse(3);
        wake();
        acc(0, 8'hb5, 8'h00, 4'h0);
        chk("fail cause", fl, sfr_rdata);
        acc(1, 8'hb5, 8'h20, 4'h0);
        fl = 8'h00;
        acc(1, 8'hb5, 8'h41, 4'h0);
        chk("suspend", 8'h01, {6'h0, sleep_mode, suspend_mode});
        @(posedge ref_clk);
        ev[0] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        acc(0, 8'hb5, 8'h00, 4'h0);
        chk("hidden flags", 8'h00, sfr_rdata);
        chk("resumed", 8'h00, {6'h0, sleep_mode, suspend_mode});
        @(posedge ref_clk);
        ev[0] <= 1'b0;
        fl[0] = 1'b1;
        acc(0, 8'hb5, 8'h00, 4'h0);
        chk("shown flags", fl, sfr_rdata);
        $display("test modes done");
        summarize();
    end
endmodule
bind power_mode_wake_control power_mode_wake_props power_mode_wake_props_i (.ref_clk, .rstn,
    .sfr_wr, .sfr_rd, .sfr_addr, .sfr_page, .sfr_wdata, .sfr_rdata, .sfr_hit, .rst_pin_n,
    .sleep_mode, .suspend_mode, .stop_req, .idle_req, .lp_osc_keep_on);
